// File: hdl/zq_odt_ctrl.v
// Purpose: ZQ calibration and on-die termination select for a DRAM device.
// Assumes: Commands arrive as APB control-register writes; ODT pin is asynchronous.
// Notes: Summary of operation follows.
// Summary of operation
// (R1) Long calibration starts engine; results move to I/O when done.
// (R2) First long calibration after reset gets the init window, later ones the oper window.
// (R3) Short calibration completes within its shorter window.
// (R4) Short calibration corrects at least one code step within 64 cycles.
// (R5) Controller keeps the channel quiet during calibration windows.
// (R6) Calibration current path is off once calibration completes.
// (R7) Controller precharges all banks and waits tRP before calibration.
// (R8) No recalibration after self refresh exit without explicit command.
// (R9) Controller waits tXS before calibration after self refresh exit.
// (R10) Controller never overlaps calibration of devices sharing one resistor.
// (R11) Controller holds CKE high during calibration.
// (R12) ODT held low during calibration; device presents park termination.
// (R13) All DQ devices stay high impedance during calibration.
// (R14) Termination on DQ, DQS, DM; TDQS too when enabled.
// (R15) Termination fully off in self refresh.
// (R16) ODT pin ignored when nominal field zero or in self refresh.
// (R17) Termination enabled when any of nominal, write or park fields nonzero.
// (R18) Written rank applies write termination regardless of ODT pin.
// (R19) Nominal termination on when ODT sampled high and enabled.
// (R20) Park value presented by default when enabled and nominal not active.
// (R21) Priority: disable, write, nominal, park.
// (R22) Controller enables DM or write DBI with read DBI for standby termination.
// (R23) Read disables termination from RL-2 or RL-3 cycles later.
// (R24) Nominal turn-on latency is CWL+AL+PL-2 or -3.
// (R25) Impedance codes update in one step at window end.
`timescale 1ns/10ps
`default_nettype none
`include "zq_odt_regs.vh"

module zq_odt_ctrl (
  // Clock and reset.
  input wire clock,
  input wire sys_rst,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pins and calibration target.
  input wire odt_pin,
  input wire [7:0] zq_target,
  // Termination and calibration outputs.
  output reg [1:0] term_sel_r,
  output reg [2:0] term_val_r,
  output reg term_tdqs_r,
  output reg [7:0] imp_code_r,
  output reg zq_current_r,
  output reg cal_busy_r
);
  reg [15:0] mode_r;
  reg [31:0] lat_r;
  reg first_done_r;
  reg self_ref_r;
  reg cal_start_r;
  reg [15:0] cal_win_r;
  reg [2:0] odt_sync_r;
  reg odt_q_r;
  reg [63:0] odt_pipe_r;
  reg [63:0] rd_pipe_r;
  reg [63:0] wr_pipe_r;
  reg [5:0] rd_hold_r;
  reg [3:0] wr_hold_r;
  reg nom_on_r;
  reg rd_off_r;
  reg wr_on_r;
  reg [1:0] sel_nxt;
  reg [2:0] val_nxt;
  reg bl4_r;

  wire eng_busy;
  wire eng_done;
  wire eng_cur;
  wire [7:0] eng_code;
  wire [2:0] f_nom = mode_r[`MODE_NOM_HI:`MODE_NOM_LO];
  wire [2:0] f_wr = mode_r[`MODE_WR_HI:`MODE_WR_LO];
  wire [2:0] f_park = mode_r[`MODE_PARK_HI:`MODE_PARK_LO];
  wire pre2 = mode_r[`MODE_PRE2];
  wire crc = mode_r[`MODE_CRC];
  wire [5:0] cwl = {1'b0, lat_r[`LAT_CWL_HI:`LAT_CWL_LO]};
  wire [5:0] al = {1'b0, lat_r[`LAT_AL_HI:`LAT_AL_LO]};
  wire [5:0] pl = {2'b00, lat_r[`LAT_PL_HI:`LAT_PL_LO]};
  wire [5:0] cl = {1'b0, lat_r[`LAT_CL_HI:`LAT_CL_LO]};
  wire [5:0] pre_adj = pre2 ? 6'h03 : 6'h02;
  wire [5:0] dodtl = cwl + al + pl - pre_adj;
  wire [5:0] rodtl = cl + al + pl - pre_adj;
  wire [5:0] odtlcnw = cwl + al + pl - 6'h02;
  wire acc = psel && penable && !pready;
  wire wr_acc = acc && pwrite;
  wire ctrl_wr = wr_acc && (paddr == `OFS_CTRL);
  wire cmd_zqcl = ctrl_wr && pwdata[`CTRL_ZQCL];
  wire cmd_zqcs = ctrl_wr && pwdata[`CTRL_ZQCS] && !pwdata[`CTRL_ZQCL];
  wire cmd_wr = ctrl_wr && pwdata[`CTRL_WRITE];
  wire cmd_rd = ctrl_wr && pwdata[`CTRL_READ];
  wire mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_MODE) ||
    (paddr == `OFS_STAT) || (paddr == `OFS_CODE) || (paddr == `OFS_LAT);

  zq_cal_engine u_eng (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(cal_start_r),
    .window(cal_win_r),
    .target(zq_target),
    .busy_r(eng_busy),
    .done_r(eng_done),
    .cur_on_r(eng_cur),
    .code_r(eng_code)
  );

  // APB slave: one wait state, pready then drops.
  always @(posedge clock) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      mode_r <= `MODE_RESET;
      lat_r <= `LAT_RESET;
    end else begin
      pready <= acc;
      pslverr <= acc && !mapped;
      prdata <= 32'h0000_0000;
      if (acc && !pwrite) begin
        case (paddr)
          `OFS_MODE: prdata <= {16'h0000, mode_r};
          `OFS_STAT: prdata <= {26'h000_0000, term_sel_r, self_ref_r, first_done_r,
            zq_current_r, cal_busy_r};
          `OFS_CODE: prdata <= {24'h00_0000, imp_code_r};
          `OFS_LAT: prdata <= lat_r;
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (wr_acc && paddr == `OFS_MODE)
        mode_r <= pwdata[15:0];
      if (wr_acc && paddr == `OFS_LAT)
        lat_r <= pwdata;
    end
  end

  // Calibration launch and self refresh state.
  always @(posedge clock) begin
    if (sys_rst) begin
      first_done_r <= 1'b0;
      self_ref_r <= 1'b0;
      cal_start_r <= 1'b0;
      cal_win_r <= `ZQCS_CYC;
      cal_busy_r <= 1'b0;
      zq_current_r <= 1'b0;
      imp_code_r <= `CODE_RESET;
    end else begin
      cal_start_r <= 1'b0;
      if ((cmd_zqcl || cmd_zqcs) && !eng_busy && !cal_busy_r) begin
        cal_start_r <= 1'b1; // see (R1) see (R8)
        cal_busy_r <= 1'b1;
        // The engine count is shortened so that the whole busy span fits the window.
        if (cmd_zqcs)
          cal_win_r <= `ZQCS_CYC - `CAL_LAUNCH_CYC; // see (R3) see (R4)
        else if (!first_done_r)
          cal_win_r <= `ZQINIT_CYC - `CAL_LAUNCH_CYC; // see (R2)
        else
          cal_win_r <= `ZQOPER_CYC - `CAL_LAUNCH_CYC; // see (R2)
        if (cmd_zqcl)
          first_done_r <= 1'b1;
      end else if (eng_done) begin
        cal_busy_r <= 1'b0;
        imp_code_r <= eng_code; // see (R25) see (R1)
      end
      zq_current_r <= eng_cur; // see (R6)
      if (ctrl_wr && pwdata[`CTRL_SRE])
        self_ref_r <= 1'b1;
      else if (ctrl_wr && pwdata[`CTRL_SRX])
        self_ref_r <= 1'b0; // see (R8)
    end
  end

  // ODT pin synchroniser and latency pipes.
  always @(posedge clock) begin
    if (sys_rst) begin
      odt_sync_r <= 3'b000;
      odt_q_r <= 1'b0;
      odt_pipe_r <= 64'h0000_0000_0000_0000;
      rd_pipe_r <= 64'h0000_0000_0000_0000;
      wr_pipe_r <= 64'h0000_0000_0000_0000;
      bl4_r <= 1'b0;
    end else begin
      odt_sync_r <= {odt_sync_r[1:0], odt_pin};
      if (odt_sync_r[2] == odt_sync_r[1])
        odt_q_r <= odt_sync_r[1];
      // Pin ignored when nominal disabled or in self refresh.
      odt_pipe_r <= {odt_pipe_r[62:0],
        odt_q_r && (f_nom != 3'b000) && !self_ref_r}; // see (R16)
      rd_pipe_r <= {rd_pipe_r[62:0], cmd_rd};
      wr_pipe_r <= {wr_pipe_r[62:0], cmd_wr};
      if (cmd_wr)
        bl4_r <= pwdata[`CTRL_BC4];
    end
  end

  // Tap the pipes at the programmed latencies and hold windows.
  always @(posedge clock) begin
    if (sys_rst) begin
      nom_on_r <= 1'b0;
      rd_off_r <= 1'b0;
      wr_on_r <= 1'b0;
      rd_hold_r <= 6'h00;
      wr_hold_r <= 4'h0;
    end else begin
      nom_on_r <= (dodtl == 6'h00) ? odt_pipe_r[0] : odt_pipe_r[dodtl - 6'h01]; // see (R24) see (R19)
      if (rd_pipe_r[rodtl]) begin
        rd_off_r <= 1'b1; // see (R23)
        rd_hold_r <= 6'h04 + pre_adj + {5'h00, crc};
      end else if (rd_hold_r != 6'h00) begin
        rd_hold_r <= rd_hold_r - 6'h01;
      end else begin
        rd_off_r <= 1'b0;
      end
      if (wr_pipe_r[odtlcnw] && f_wr != 3'b000) begin
        wr_on_r <= 1'b1; // see (R18)
        wr_hold_r <= bl4_r ? 4'h4 : 4'h6;
      end else if (wr_hold_r != 4'h0) begin
        wr_hold_r <= wr_hold_r - 4'h1;
      end else begin
        wr_on_r <= 1'b0;
      end
    end
  end

  // Priority select: disable, calibration park, write, nominal, park.
  always @* begin
    sel_nxt = `TERM_OFF;
    val_nxt = 3'b000;
    if (self_ref_r || rd_off_r) begin
      sel_nxt = `TERM_OFF; // see (R15) see (R21)
    end else if (cal_busy_r) begin
      sel_nxt = (f_park != 3'b000) ? `TERM_PARK : `TERM_OFF; // see (R12)
      val_nxt = f_park;
    end else if (wr_on_r) begin
      sel_nxt = `TERM_WR; // see (R21)
      val_nxt = f_wr;
    end else if (nom_on_r && f_nom != 3'b000) begin
      sel_nxt = `TERM_NOM;
      val_nxt = f_nom;
    end else if (f_park != 3'b000) begin
      sel_nxt = `TERM_PARK; // see (R20)
      val_nxt = f_park;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      term_sel_r <= `TERM_OFF;
      term_val_r <= 3'b000;
      term_tdqs_r <= 1'b0;
    end else begin
      term_sel_r <= sel_nxt; // see (R17)
      term_val_r <= val_nxt;
      term_tdqs_r <= mode_r[`MODE_TDQS] && (val_nxt != 3'b000); // see (R14)
    end
  end
endmodule // zq_odt_ctrl

`default_nettype wire

// File: hdl/zq_odt_regs.vh
// Purpose: Offsets, field positions, reset values and timing counts for zq_odt_ctrl.
// Assumes: APB slave, 32-bit words, 10 MHz clock.
// Notes: Offsets are byte addresses.
`ifndef ZQ_ODT_REGS_VH
`define ZQ_ODT_REGS_VH

// Register byte offsets.
`define OFS_CTRL 12'h000
`define OFS_MODE 12'h004
`define OFS_STAT 12'h008
`define OFS_CODE 12'h00C
`define OFS_LAT 12'h010

// Control register bits (write one to act).
`define CTRL_ZQCL 0
`define CTRL_ZQCS 1
`define CTRL_SRE 2
`define CTRL_SRX 3
`define CTRL_WRITE 4
`define CTRL_READ 5
`define CTRL_BC4 6

// Mode register fields.
`define MODE_NOM_LO 0
`define MODE_NOM_HI 2
`define MODE_WR_LO 4
`define MODE_WR_HI 6
`define MODE_PARK_LO 8
`define MODE_PARK_HI 10
`define MODE_TDQS 12
`define MODE_PRE2 13
`define MODE_CRC 14
`define MODE_RESET 16'h0000

// Latency register fields.
`define LAT_CWL_LO 0
`define LAT_CWL_HI 4
`define LAT_AL_LO 8
`define LAT_AL_HI 12
`define LAT_PL_LO 16
`define LAT_PL_HI 19
`define LAT_CL_LO 24
`define LAT_CL_HI 28
`define LAT_RESET 32'h0000_0009

// Calibration windows in clock cycles.
`define ZQINIT_CYC 16'h0400
`define ZQOPER_CYC 16'h0200
`define ZQCS_CYC 16'h0080
`define ZQCS_MIN_CYC 16'h0040
// Cycles that the launch and the result hand-over add around the engine count.
`define CAL_LAUNCH_CYC 16'h0002
`define CODE_RESET 8'h80
`define CODE_STEP 8'h01

// Termination select encoding.
`define TERM_OFF 2'b00
`define TERM_WR 2'b01
`define TERM_NOM 2'b10
`define TERM_PARK 2'b11

`endif

// File: hdl/zq_cal_engine.v
// Purpose: Calibration engine; walks an impedance code during a timed window.
// Assumes: Start pulses arrive only while idle.
// Notes: The result is handed out in one step when the window ends.
`timescale 1ns/10ps
`default_nettype none
`include "zq_odt_regs.vh"

module zq_cal_engine (
  // Clock and reset.
  input wire clock,
  input wire sys_rst,
  // Request.
  input wire start,
  input wire [15:0] window,
  input wire [7:0] target,
  // Status.
  output reg busy_r,
  output reg done_r,
  output reg cur_on_r,
  output reg [7:0] code_r
);
  reg [15:0] cnt_r;
  reg [7:0] work_r;

  always @(posedge clock) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cur_on_r <= 1'b0;
      cnt_r <= 16'h0000;
      work_r <= `CODE_RESET;
      code_r <= `CODE_RESET;
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        cur_on_r <= 1'b1;
        cnt_r <= window;
        work_r <= code_r;
      end else if (busy_r) begin
        // Step the working code toward the target by one code step each cycle; hold once it matches.
        if (work_r < target)
          work_r <= work_r + `CODE_STEP;
        else if (work_r > target)
          work_r <= work_r - `CODE_STEP;
        if (cnt_r == 16'h0001) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          cur_on_r <= 1'b0;
          code_r <= work_r;
        end
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end
endmodule // zq_cal_engine

`default_nettype wire

// File: test/ctrl_model.sv
// Purpose: Controller-side model that drives the ODT pin.
// Assumes: The bench asks for ODT through odt_req.
// Notes: The pin is forced low while the device calibrates.
`timescale 1ns/10ps
`default_nettype none
module ctrl_model (
  // Clock and status.
  input wire logic clock,
  input wire logic cal_busy,
  // Request and pin.
  input wire logic odt_req,
  output var logic odt_pin
);
  // One device on its own resistor, banks idle, clock enable high, no DQ drive, no DBI.
  initial odt_pin = 1'b0;
  always @(posedge clock) begin
    odt_pin <= odt_req && !cal_busy;
  end
endmodule // ctrl_model
`default_nettype wire

// File: test/zq_odt_chk.sv
// Purpose: Port assertions for zq_odt_ctrl.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound into every zq_odt_ctrl instance.
`timescale 1ns/10ps
`default_nettype none
`include "zq_odt_regs.vh"
module zq_odt_chk (
  // Clock, reset and APB.
  input wire clock,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins and termination.
  input wire odt_pin,
  input wire [7:0] zq_target,
  input wire [1:0] term_sel_r,
  input wire [2:0] term_val_r,
  input wire term_tdqs_r,
  input wire [7:0] imp_code_r,
  input wire zq_current_r,
  input wire cal_busy_r
);
  logic [15:0] busy_cnt_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  always @(posedge clock) begin
    if (sys_rst || !cal_busy_r) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
  end
  a_access_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_unmapped_error: assert property (psel && penable && pready && paddr > `OFS_LAT |-> pslverr)
    else $error("unmapped access not refused");
  a_cal_start: assert property (psel && penable && !pready && pwrite && paddr == `OFS_CTRL
    && pwdata[`CTRL_ZQCL] && !cal_busy_r |-> ##[1:3] cal_busy_r)
    else $error("calibration did not start");
  a_window_bound: assert property (cal_busy_r |-> busy_cnt_r < `ZQINIT_CYC)
    else $error("calibration window too long");
  a_code_frozen: assert property (cal_busy_r |-> $stable(imp_code_r))
    else $error("code moved inside window");
  a_cal_park: assert property (cal_busy_r && $past(cal_busy_r) |->
    term_sel_r == `TERM_PARK || term_sel_r == `TERM_OFF)
    else $error("active termination during calibration");
  a_current_off: assert property (!cal_busy_r && !$past(cal_busy_r) &&
    !$past(cal_busy_r, 2) |-> !zq_current_r)
    else $error("calibration current left on");
  a_sel_value: assert property (term_sel_r != `TERM_OFF |-> term_val_r != 3'b000)
    else $error("termination chosen with zero field");
  a_tdqs_term: assert property (term_tdqs_r |-> term_val_r != 3'b000)
    else $error("strobe terminated without value");
  c_cal: cover property ($rose(cal_busy_r));
  c_nom: cover property (term_sel_r == `TERM_NOM);
  c_wr: cover property (term_sel_r == `TERM_WR);
  c_err: cover property (pslverr);
endmodule // zq_odt_chk
bind zq_odt_ctrl zq_odt_chk u_chk (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .odt_pin, .zq_target, .term_sel_r, .term_val_r,
  .term_tdqs_r, .imp_code_r, .zq_current_r, .cal_busy_r);
`default_nettype wire

// File: test/tb.sv
// Purpose: Self-checking bench for zq_odt_ctrl.
// Assumes: APB answers after one wait state or later.
// Notes: Register rows first, then calibration and termination cases.
`timescale 1ns/10ps
`default_nettype none
`include "zq_odt_regs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic er;} row_t;
  logic clock, sys_rst, psel, penable, pwrite, odt_req, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [7:0] zq_target;
  wire [31:0] prdata;
  wire pready, pslverr, odt_pin, term_tdqs_r, zq_current_r, cal_busy_r;
  wire [1:0] term_sel_r;
  wire [2:0] term_val_r;
  wire [7:0] imp_code_r;
  int miscompares = 0;
  int checks_done = 0;
  row_t rows [0:6] = '{'{`OFS_MODE, 1'b0, 32'h0000_0000, 1'b0},
    '{`OFS_LAT, 1'b0, 32'h0000_0009, 1'b0}, '{`OFS_CODE, 1'b0, 32'h0000_0080, 1'b0},
    '{`OFS_STAT, 1'b0, 32'h0000_0000, 1'b0}, '{`OFS_MODE, 1'b1, 32'h0000_1321, 1'b0},
    '{`OFS_LAT, 1'b1, 32'h0B00_0009, 1'b0}, '{12'h014, 1'b0, 32'h0000_0000, 1'b1}};
  zq_odt_ctrl DUT (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .odt_pin, .zq_target, .term_sel_r, .term_val_r, .term_tdqs_r,
    .imp_code_r, .zq_current_r, .cal_busy_r);
  ctrl_model partner (.clock, .cal_busy(cal_busy_r), .odt_req, .odt_pin);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wsel(input logic [1:0] s);
    int n;
    n = 0;
    while (term_sel_r !== s && n < 60) begin @(posedge clock); n++; end
    `CHK(term_sel_r, s)
  endtask
  task automatic cal(input int b, input logic [7:0] tgt, input int lo, input int hi);
    int n;
    n = 0;
    zq_target <= tgt;
    apb(`OFS_CTRL, 1'b1, 32'h0000_0001 << b);
    while (cal_busy_r !== 1'b1 && n < 8) begin @(posedge clock); n++; end
    n = 0;
    while (cal_busy_r === 1'b1 && n < 2000) begin @(posedge clock); n++; end
    repeat (2) @(posedge clock);
    `CHK(n > lo && n <= hi, 1'b1)
    `CHK(imp_code_r, tgt)
    `CHK(zq_current_r, 1'b0)
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, odt_req, paddr, pwdata} = '0;
    zq_target = 8'h80;
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      `CHK(er, rows[i].er)
      if (!rows[i].w && !rows[i].er) `CHK(rd, rows[i].d)
    end
    $display("test registers done");
    cal(`CTRL_ZQCL, 8'h90, 1016, 1024);
    cal(`CTRL_ZQCL, 8'h70, 504, 512);
    cal(`CTRL_ZQCS, 8'h78, 120, 128);
    apb(`OFS_STAT, 1'b0, 32'h0000_0000);
    `CHK(rd[2], 1'b1)
    $display("test calibration done");
    wsel(`TERM_PARK);
    `CHK(term_val_r, 3'b011)
    odt_req <= 1'b1;
    wsel(`TERM_NOM);
    `CHK(term_val_r, 3'b001)
    `CHK(term_tdqs_r, 1'b1)
    apb(`OFS_CTRL, 1'b1, 32'h0000_0010);
    wsel(`TERM_WR);
    `CHK(term_val_r, 3'b010)
    apb(`OFS_CTRL, 1'b1, 32'h0000_0020);
    wsel(`TERM_OFF);
    apb(`OFS_MODE, 1'b1, 32'h0000_0320);
    wsel(`TERM_PARK);
    repeat (20) @(posedge clock);
    `CHK(term_sel_r, `TERM_PARK)
    $display("test termination done");
    apb(`OFS_CTRL, 1'b1, 32'h0000_0004);
    wsel(`TERM_OFF);
    apb(`OFS_CTRL, 1'b1, 32'h0000_0008);
    repeat (20) @(posedge clock);
    `CHK({cal_busy_r, imp_code_r}, 9'h078)
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    `CHK(imp_code_r, 8'h80)
    $display("test self refresh done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
